//--- hdl/limit_alert_bank.v
// Purpose: Limit thresholds, alert enables, flags and alert line
// Assumes: Measurements and charger state arrive on clk, signed words
// Notes:   Words go low byte first; command byte auto-increments
// Function
// - Every register sixteen bits, active high
// - Limit thresholds compare as signed numbers
// - Battery limits share battery measurement encoding
// - Input and system limits share measurement encoding
// - Current limits share current measurement encoding
// - Die heat, resistance limits share encoding
// - Ratio high means cold, low hot
// - Limit enable register, resets to zero
// - Limit enable bit positions fixed
// - Enabled limit alert sets matching flag
// - Charger state enables gate bits ten:six
// - Alert line low until alert response
// - Flags clear only by writing zero
`include "limit_alert_regs.vh"
module limit_alert_bank
(
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Serial pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    output wire        alert_out,
    output wire        alert_oe,
    // Measurements
    input  wire [15:0] battery_voltage,
    input  wire [15:0] input_voltage,
    input  wire [15:0] system_voltage,
    input  wire [15:0] input_current,
    input  wire [15:0] charge_current,
    input  wire [15:0] die_heat,
    input  wire [15:0] thermistor_ratio,
    input  wire [15:0] series_resistance,
    // Events from other blocks
    input  wire        meas_valid_event,
    input  wire        charge_count_low_event,
    input  wire        charge_count_high_event,
    input  wire [15:0] charger_state_event
);

reg  [1:0]  scl_sync_r;
reg  [1:0]  sda_sync_r;
reg  [15:0] limit_r [1:12];
reg  [15:0] limit_alert_enables_r;
reg  [15:0] charger_state_alert_enables_r;
reg  [15:0] limit_flags_r;
reg  [15:0] state_flags_r;
reg  [15:0] limit_flags_nxt;
reg  [15:0] state_flags_nxt;
reg  [7:0]  cmd_r;
reg         cmd_loaded_r;
reg         byte_hi_r;
reg  [7:0]  low_byte_r;
reg  [15:0] rd_word_r;
reg         alert_r;
reg  [15:0] limit_hit;
reg  [15:0] write_clear;
reg  [15:0] state_write_clear;

wire        start_p;
wire        stop_p;
wire        addr_wr_p;
wire        wr_byte_p;
wire [7:0]  wr_byte;
wire        rd_req_p;
wire        ara_done_p;
wire [15:0] full_word = {wr_byte, low_byte_r};
wire        word_done = wr_byte_p & cmd_loaded_r & byte_hi_r;
wire        battery_voltage_low_notify_enable =
            limit_alert_enables_r[`BIT_BATTERY_VOLTAGE_LOW];
wire        battery_voltage_high_notify_enable =
            limit_alert_enables_r[`BIT_BATTERY_VOLTAGE_HIGH];
wire        input_voltage_low_notify_enable =
            limit_alert_enables_r[`BIT_INPUT_VOLTAGE_LOW];
wire        input_voltage_high_notify_enable =
            limit_alert_enables_r[`BIT_INPUT_VOLTAGE_HIGH];
wire        system_voltage_low_notify_enable =
            limit_alert_enables_r[`BIT_SYSTEM_VOLTAGE_LOW];
wire        system_voltage_high_notify_enable =
            limit_alert_enables_r[`BIT_SYSTEM_VOLTAGE_HIGH];
wire        input_current_high_notify_enable =
            limit_alert_enables_r[`BIT_INPUT_CURRENT_HIGH];
wire        charge_current_low_notify_enable =
            limit_alert_enables_r[`BIT_CHARGE_CURRENT_LOW];
wire        die_heat_notify_enable =
            limit_alert_enables_r[`BIT_DIE_HEAT_HIGH];
wire        resistance_high_notify_enable =
            limit_alert_enables_r[`BIT_RESISTANCE_HIGH];
wire        cold_battery_notify_enable =
            limit_alert_enables_r[`BIT_COLD_BATTERY];
wire        hot_battery_notify_enable =
            limit_alert_enables_r[`BIT_HOT_BATTERY];

// Signed compare: measurement below threshold
function below;
    input [15:0] meas;
    input [15:0] lim;
    begin
        below = $signed(meas) < $signed(lim);
    end
endfunction

// Own address is fixed; change the parameter per board
parameter [6:0] DEVICE_ADDR = `DEVICE_ADDR_DEFAULT;

always @(posedge clk)
begin
    if (!reset_n)
    begin
        scl_sync_r <= 2'b11;
        sda_sync_r <= 2'b11;
    end
    else
    begin
        scl_sync_r <= {scl_sync_r[0], scl_in};
        sda_sync_r <= {sda_sync_r[0], sda_in};
    end
end

serial_slave u_slave
(
    .clk        (clk),
    .reset_n    (reset_n),
    .scl_s      (scl_sync_r[1]),
    .sda_s      (sda_sync_r[1]),
    .sda_oe     (sda_oe),
    .own_addr   (DEVICE_ADDR),
    .ara_armed  (alert_r),
    .start_p    (start_p),
    .stop_p     (stop_p),
    .addr_wr_p  (addr_wr_p),
    .wr_byte_p  (wr_byte_p),
    .wr_byte    (wr_byte),
    .rd_req_p   (rd_req_p),
    .rd_byte    (byte_hi_r ? rd_word_r[15:8] : rd_word_r[7:0]),
    .ara_done_p (ara_done_p)
);

assign sda_out   = 1'b0;
assign alert_out = 1'b0;
assign alert_oe  = alert_r;

// Read mux; reserved bits and unmapped commands read zero
always @(posedge clk)
begin
    if (!reset_n)
        rd_word_r <= 16'h0000;
    else if (cmd_r >= `BATTERY_VOLTAGE_LOW_LIMIT_OFF &&
             cmd_r <= `THERMISTOR_HOT_LIMIT_OFF)
        rd_word_r <= limit_r[cmd_r[3:0]];
    else if (cmd_r == `LIMIT_ALERT_ENABLES_OFF)
        rd_word_r <= limit_alert_enables_r;
    else if (cmd_r == `CHARGER_STATE_ALERT_ENABLES_OFF)
        rd_word_r <= charger_state_alert_enables_r;
    else if (cmd_r == `LIMIT_ALERT_FLAGS_OFF)
        rd_word_r <= limit_flags_r;
    else if (cmd_r == `CHARGER_STATE_ALERT_FLAGS_OFF)
        rd_word_r <= state_flags_r;
    else
        rd_word_r <= 16'h0000;
end

// Command pointer and byte pairing
always @(posedge clk)
begin
    if (!reset_n)
    begin
        cmd_r        <= 8'h00;
        cmd_loaded_r <= 1'b0;
        byte_hi_r    <= 1'b0;
        low_byte_r   <= 8'h00;
    end
    else if (start_p || stop_p)
    begin
        cmd_loaded_r <= 1'b0;
        byte_hi_r    <= 1'b0;
    end
    else if (addr_wr_p)
        cmd_loaded_r <= 1'b0;
    else if (wr_byte_p && !cmd_loaded_r)
    begin
        cmd_r        <= wr_byte;
        cmd_loaded_r <= 1'b1;
        byte_hi_r    <= 1'b0;
    end
    else if (wr_byte_p || rd_req_p)
    begin
        low_byte_r <= wr_byte;
        byte_hi_r  <= ~byte_hi_r;
        if (byte_hi_r)
            cmd_r <= cmd_r + 8'h01;
    end
end

// Threshold and enable registers
genvar gi;
generate
    for (gi = 1; gi <= 12; gi = gi + 1)
    begin : g_limit
        always @(posedge clk)
        begin
            if (!reset_n)
                limit_r[gi] <= `LIMIT_RESET_VALUE;
            else if (word_done && cmd_r == gi)
                limit_r[gi] <= full_word;
        end
    end
endgenerate

always @(posedge clk)
begin
    if (!reset_n)
    begin
        limit_alert_enables_r         <= `ENABLE_RESET_VALUE;
        charger_state_alert_enables_r <= `ENABLE_RESET_VALUE;
    end
    else if (word_done && cmd_r == `LIMIT_ALERT_ENABLES_OFF)
        limit_alert_enables_r <= full_word & `LIMIT_ENABLE_MASK;
    else if (word_done && cmd_r == `CHARGER_STATE_ALERT_ENABLES_OFF)
        charger_state_alert_enables_r <=
            full_word & `STATE_ENABLE_MASK;
end

// Limit detection per enabled bit
always @*
begin
    limit_hit = 16'h0000;
    limit_hit[`BIT_MEAS_VALID] = meas_valid_event;
    limit_hit[`BIT_CHARGE_COUNT_LOW] = charge_count_low_event;
    limit_hit[`BIT_CHARGE_COUNT_HIGH] = charge_count_high_event;
    limit_hit[`BIT_BATTERY_VOLTAGE_LOW] = battery_voltage_low_notify_enable &
        below(battery_voltage, limit_r[1]);
    limit_hit[`BIT_BATTERY_VOLTAGE_HIGH] = battery_voltage_high_notify_enable &
        below(limit_r[2], battery_voltage);
    limit_hit[`BIT_INPUT_VOLTAGE_LOW] = input_voltage_low_notify_enable &
        below(input_voltage, limit_r[3]);
    limit_hit[`BIT_INPUT_VOLTAGE_HIGH] = input_voltage_high_notify_enable &
        below(limit_r[4], input_voltage);
    limit_hit[`BIT_SYSTEM_VOLTAGE_LOW] = system_voltage_low_notify_enable &
        below(system_voltage, limit_r[5]);
    limit_hit[`BIT_SYSTEM_VOLTAGE_HIGH] = system_voltage_high_notify_enable &
        below(limit_r[6], system_voltage);
    limit_hit[`BIT_INPUT_CURRENT_HIGH] = input_current_high_notify_enable &
        below(limit_r[7], input_current);
    limit_hit[`BIT_CHARGE_CURRENT_LOW] = charge_current_low_notify_enable &
        below(charge_current, limit_r[8]);
    limit_hit[`BIT_DIE_HEAT_HIGH] = die_heat_notify_enable &
        below(limit_r[9], die_heat);
    limit_hit[`BIT_RESISTANCE_HIGH] = resistance_high_notify_enable &
        below(limit_r[10], series_resistance);
    limit_hit[`BIT_COLD_BATTERY] = cold_battery_notify_enable &
        below(limit_r[11], thermistor_ratio);
    limit_hit[`BIT_HOT_BATTERY] = hot_battery_notify_enable &
        below(thermistor_ratio, limit_r[12]);
    limit_hit = limit_hit & limit_alert_enables_r;
end

// Flags: write of zero clears a bit, a new hit in the same cycle wins
always @*
begin
    write_clear = 16'h0000;
    state_write_clear = 16'h0000;
    if (word_done && cmd_r == `LIMIT_ALERT_FLAGS_OFF)
        write_clear = ~full_word;
    if (word_done && cmd_r == `CHARGER_STATE_ALERT_FLAGS_OFF)
        state_write_clear = ~full_word;
    limit_flags_nxt = (limit_flags_r & ~write_clear) | limit_hit;
    state_flags_nxt = (state_flags_r & ~state_write_clear) |
        (charger_state_event & charger_state_alert_enables_r);
end

always @(posedge clk)
begin
    if (!reset_n)
    begin
        limit_flags_r <= 16'h0000;
        state_flags_r <= 16'h0000;
        alert_r       <= 1'b0;
    end
    else
    begin
        limit_flags_r <= limit_flags_nxt;
        state_flags_r <= state_flags_nxt;
        // A flag rising in the response cycle wins over the release
        if (|(limit_flags_nxt & ~limit_flags_r) ||
            |(state_flags_nxt & ~state_flags_r))
            alert_r <= 1'b1;
        else if (ara_done_p)
            alert_r <= 1'b0;
    end
end

endmodule

//--- hdl/limit_alert_regs.vh
// Purpose: Offsets, field positions and reset values of the limit alert bank
// Assumes: 7-bit device address, 8-bit command code, 16-bit words low first
// Notes:   Included by the bank design file, the host model and the bench
`ifndef LIMIT_ALERT_REGS_VH
`define LIMIT_ALERT_REGS_VH

`define BATTERY_VOLTAGE_LOW_LIMIT_OFF    8'h01
`define BATTERY_VOLTAGE_HIGH_LIMIT_OFF   8'h02
`define INPUT_VOLTAGE_LOW_LIMIT_OFF      8'h03
`define INPUT_VOLTAGE_HIGH_LIMIT_OFF     8'h04
`define SYSTEM_VOLTAGE_LOW_LIMIT_OFF     8'h05
`define SYSTEM_VOLTAGE_HIGH_LIMIT_OFF    8'h06
`define INPUT_CURRENT_HIGH_LIMIT_OFF     8'h07
`define CHARGE_CURRENT_LOW_LIMIT_OFF     8'h08
`define DIE_HEAT_HIGH_LIMIT_OFF          8'h09
`define SERIES_RESISTANCE_HIGH_LIMIT_OFF 8'h0a
`define THERMISTOR_COLD_LIMIT_OFF        8'h0b
`define THERMISTOR_HOT_LIMIT_OFF         8'h0c
`define LIMIT_ALERT_ENABLES_OFF          8'h0d
`define CHARGER_STATE_ALERT_ENABLES_OFF  8'h0e
`define LIMIT_ALERT_FLAGS_OFF            8'h36
`define CHARGER_STATE_ALERT_FLAGS_OFF    8'h37
`define BATTERY_VOLTAGE_OFF              8'h3a
`define INPUT_VOLTAGE_OFF                8'h3b
`define SYSTEM_VOLTAGE_OFF               8'h3c
`define INPUT_CURRENT_OFF                8'h3d
`define CHARGE_CURRENT_OFF               8'h3e
`define DIE_HEAT_OFF                     8'h3f
`define THERMISTOR_RATIO_OFF             8'h40
`define SERIES_RESISTANCE_OFF            8'h41

`define LIMIT_RESET_VALUE                16'h0000
`define ENABLE_RESET_VALUE               16'h0000
`define LIMIT_ENABLE_MASK                16'hbfff
`define STATE_ENABLE_MASK                16'h07c0

`define BIT_MEAS_VALID                   15
`define BIT_CHARGE_COUNT_LOW             13
`define BIT_CHARGE_COUNT_HIGH            12
`define BIT_BATTERY_VOLTAGE_LOW          11
`define BIT_BATTERY_VOLTAGE_HIGH         10
`define BIT_INPUT_VOLTAGE_LOW            9
`define BIT_INPUT_VOLTAGE_HIGH           8
`define BIT_SYSTEM_VOLTAGE_LOW           7
`define BIT_SYSTEM_VOLTAGE_HIGH          6
`define BIT_INPUT_CURRENT_HIGH           5
`define BIT_CHARGE_CURRENT_LOW           4
`define BIT_DIE_HEAT_HIGH                3
`define BIT_RESISTANCE_HIGH              2
`define BIT_COLD_BATTERY                 1
`define BIT_HOT_BATTERY                  0

`define ALERT_RESPONSE_ADDR              7'h0c
`define DEVICE_ADDR_DEFAULT              7'h68

`endif

//--- hdl/serial_slave.v
// Purpose: Two-wire serial slave, byte level, sampled on clk
// Assumes: Bus lines already passed two flip-flops
// Notes:   Answers own address and, when armed, the alert response address
module serial_slave
(
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Synchronised bus levels
    input  wire        scl_s,
    input  wire        sda_s,
    // Data line drive
    output reg         sda_oe,
    // Addressing
    input  wire [6:0]  own_addr,
    input  wire        ara_armed,
    // Byte side
    output reg         start_p,
    output reg         stop_p,
    output reg         addr_wr_p,
    output reg         wr_byte_p,
    output reg  [7:0]  wr_byte,
    output reg         rd_req_p,
    input  wire [7:0]  rd_byte,
    output reg         ara_done_p
);

localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_AACK = 3'd2;
localparam ST_WRB  = 3'd3;
localparam ST_WACK = 3'd4;
localparam ST_RDB  = 3'd5;
localparam ST_RACK = 3'd6;
localparam ST_ARA  = 3'd7;

reg        scl_q;
reg        sda_q;
reg [2:0]  state_r;
reg [3:0]  cnt_r;
reg [7:0]  sh_r;
reg        rd_dir_r;
reg        is_ara_r;

wire scl_rise = scl_s & ~scl_q;
wire scl_fall = ~scl_s & scl_q;
wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

always @(posedge clk)
begin
    start_p    <= 1'b0;
    stop_p     <= 1'b0;
    addr_wr_p  <= 1'b0;
    wr_byte_p  <= 1'b0;
    rd_req_p   <= 1'b0;
    ara_done_p <= 1'b0;
    if (!reset_n)
    begin
        scl_q    <= 1'b1;
        sda_q    <= 1'b1;
        state_r  <= ST_IDLE;
        cnt_r    <= 4'h0;
        sh_r     <= 8'h00;
        rd_dir_r <= 1'b0;
        is_ara_r <= 1'b0;
        sda_oe   <= 1'b0;
        wr_byte  <= 8'h00;
    end
    else
    begin
        scl_q <= scl_s;
        sda_q <= sda_s;
        if (start_c)
        begin
            start_p <= 1'b1;
            state_r <= ST_ADDR;
            cnt_r   <= 4'h0;
            sda_oe  <= 1'b0;
        end
        else if (stop_c)
        begin
            stop_p  <= 1'b1;
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    sda_oe <= 1'b0;
                ST_ADDR, ST_WRB:
                    if (scl_rise)
                    begin
                        sh_r  <= {sh_r[6:0], sda_s};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == 4'h8)
                    begin
                        cnt_r <= 4'h0;
                        if (state_r == ST_ADDR)
                        begin
                            rd_dir_r <= sh_r[0];
                            is_ara_r <= ara_armed && sh_r[0] &&
                                        sh_r[7:1] == `ALERT_RESPONSE_ADDR;
                            if (sh_r[7:1] == own_addr ||
                                (ara_armed && sh_r[0] &&
                                 sh_r[7:1] == `ALERT_RESPONSE_ADDR))
                            begin
                                sda_oe  <= 1'b1;
                                state_r <= ST_AACK;
                                if (!sh_r[0])
                                    addr_wr_p <= 1'b1;
                            end
                            else
                                state_r <= ST_IDLE;
                        end
                        else
                        begin
                            wr_byte   <= sh_r;
                            wr_byte_p <= 1'b1;
                            sda_oe    <= 1'b1;
                            state_r   <= ST_WACK;
                        end
                    end
                ST_AACK, ST_WACK:
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        if (!rd_dir_r)
                            state_r <= ST_WRB;
                        else if (is_ara_r)
                        begin
                            sh_r    <= {own_addr, 1'b0};
                            sda_oe  <= ~own_addr[6];
                            state_r <= ST_ARA;
                        end
                        else
                        begin
                            sh_r    <= rd_byte;
                            sda_oe  <= ~rd_byte[7];
                            rd_req_p <= 1'b1;
                            state_r <= ST_RDB;
                        end
                    end
                ST_RDB, ST_ARA:
                    if (scl_fall)
                    begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == 4'h7)
                        begin
                            sda_oe  <= 1'b0;
                            state_r <= ST_RACK;
                            if (state_r == ST_ARA)
                                ara_done_p <= 1'b1;
                        end
                        else
                        begin
                            sh_r   <= {sh_r[6:0], 1'b0};
                            sda_oe <= ~sh_r[6];
                        end
                    end
                ST_RACK:
                    if (scl_rise)
                    begin
                        cnt_r <= 4'h0;
                        // Nack from master ends the read
                        state_r <= (sda_s || is_ara_r) ? ST_IDLE : ST_AACK;
                    end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
end

endmodule

//--- verification/limit_alert_bank_assertions.sv
// Purpose: Port-level checks on the serial and alert pins
// Assumes: scl_in and sda_in are the raw wire levels
// Notes:   Sync lag is 2-3 clk, so edges are compared with slack
module limit_alert_bank_checker
(
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Serial pins
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire alert_out,
    input wire alert_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Both lines high this long only happens between frames
    sequence idle8;
        (scl_in && sda_in)[*8];
    endsequence
    sequence drive_run;
        sda_oe[*6];
    endsequence
    AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    AST_ALERT_OUT_LOW: assert property (alert_out == 1'b0)
        else $error("alert_out not low");
    AST_RESET_QUIET: assert property (
        $rose(reset_n) |-> !alert_oe && !sda_oe)
        else $error("pins driven after reset");
    AST_EDGE_SAFE: assert property (
        $changed(sda_oe) |-> !$past(scl_in, 2))
        else $error("sda drive changed with clock high");
    AST_IDLE_RELEASE: assert property (
        idle8 ##1 !sda_in |-> !sda_oe)
        else $error("sda driven at start of frame");
    AST_IDLE_HOLDS_ALERT: assert property (
        (alert_oe && scl_in && sda_in)[*8] |=> alert_oe)
        else $error("alert released without response read");
    AST_DRIVE_MIN: assert property ($rose(sda_oe) |-> drive_run)
        else $error("sda low drive shorter than a bit");
    AST_ALERT_STAYS: assert property (
        $rose(alert_oe) |=> alert_oe[*8])
        else $error("alert pulse too short");
    COV_RELEASE: cover property ($fell(alert_oe));
endmodule
bind limit_alert_bank limit_alert_bank_checker checker_i
(
    .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out),
    .alert_oe(alert_oe)
);

//--- verification/smbus_host.sv
// Purpose: Bit-banged serial host with alert response read
// Assumes: 8 clk per bit, wire pulled up outside
// Notes:   Clock line rests high between frames
`include "limit_alert_regs.vh"
module smbus_host
(
    // Clock
    input  wire  clk,
    // Bus lines
    input  wire  sda,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] r0, r1, r2, r3, r4;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task q;
        repeat (2) @(posedge clk);
    endtask
    task xbit(input logic b, output logic r);
        sda_pull <= !b;
        q;
        scl <= 1'b1;
        q;
        r = sda;
        q;
        scl <= 1'b0;
        q;
    endtask
    task start;
        sda_pull <= 1'b1;
        q;
        scl <= 1'b0;
        q;
    endtask
    // Extra wait lets the slave drop its acknowledge before clock rises
    task rstart;
        sda_pull <= 1'b0;
        q;
        q;
        scl <= 1'b1;
        q;
        start;
    endtask
    task stop;
        sda_pull <= 1'b1;
        q;
        scl <= 1'b1;
        q;
        sda_pull <= 1'b0;
        q;
    endtask
    task xbyte(input logic [7:0] d, input logic a, output logic [8:0] r);
        logic [8:0] v;
        v = {d, a};
        for (int i = 8; i >= 0; i--)
            xbit(v[i], r[i]);
    endtask
    task wr(input logic [6:0] a, input logic [7:0] c,
            input logic [15:0] w, output logic ok);
        start;
        xbyte({a, 1'b0}, 1'b1, r0);
        xbyte(c, 1'b1, r1);
        xbyte(w[7:0], 1'b1, r2);
        xbyte(w[15:8], 1'b1, r3);
        stop;
        ok = !(r0[0] | r1[0] | r2[0] | r3[0]);
    endtask
    task rd(input logic [6:0] a, input logic [7:0] c,
            output logic [15:0] w, output logic ok);
        start;
        xbyte({a, 1'b0}, 1'b1, r0);
        xbyte(c, 1'b1, r1);
        rstart;
        xbyte({a, 1'b1}, 1'b1, r2);
        xbyte(8'hff, 1'b0, r3);
        xbyte(8'hff, 1'b1, r4);
        stop;
        w = {r4[8:1], r3[8:1]};
        ok = !(r0[0] | r1[0] | r2[0]);
    endtask
    task ara(output logic [7:0] id, output logic ok);
        start;
        xbyte({`ALERT_RESPONSE_ADDR, 1'b1}, 1'b1, r0);
        xbyte(8'hff, 1'b1, r1);
        stop;
        id = r1[8:1];
        ok = !r0[0];
    endtask
endmodule

//--- verification/limit_alert_bank_tb.sv
// Purpose: Self-checking bench for the limit alert bank
// Assumes: Host model drives the pins, shadow array models registers
// Notes:   Limits straddle zero so an unsigned compare gets caught
`include "limit_alert_regs.vh"
module limit_alert_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        reset_n;
    logic [15:0] meas [0:8];
    logic        valid_ev, cnt_lo_ev, cnt_hi_ev;
    logic [15:0] state_ev;
    logic [15:0] shadow [0:255];
    logic [15:0] rdw;
    logic [7:0]  aid, ec;
    logic        ok;
    wire         scl, host_pull, sda_oe, alert_oe;
    wire         sda = !(host_pull || sda_oe);
    int          mismatches, tests_run, lim, eb;
    int          seed = 32'h3f0b;
    int          mi [1:12] = '{0, 0, 1, 1, 2, 2, 3, 4, 5, 7, 6, 6};
    bit          hi [1:12] = '{0, 1, 0, 1, 0, 1, 1, 0, 1, 1, 1, 0};
    limit_alert_bank limit_alert_bank_i
    (
        .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .alert_out(), .alert_oe(alert_oe),
        .battery_voltage(meas[0]), .input_voltage(meas[1]),
        .system_voltage(meas[2]), .input_current(meas[3]),
        .charge_current(meas[4]), .die_heat(meas[5]),
        .thermistor_ratio(meas[6]), .series_resistance(meas[7]),
        .meas_valid_event(valid_ev), .charge_count_low_event(cnt_lo_ev),
        .charge_count_high_event(cnt_hi_ev),
        .charger_state_event(state_ev)
    );
    smbus_host smbus_host_i
    (
        .clk(clk), .sda(sda), .scl(scl), .sda_pull(host_pull)
    );
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task check_word(input logic [15:0] got, input logic [15:0] want);
        tests_run++;
        if (got !== want)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task check_bit(input logic got, input logic want);
        check_word({15'h0, got}, {15'h0, want});
    endtask
    // Unused enable bits are never written, so the value is masked first
    task put(input logic [7:0] c, input logic [15:0] w);
        shadow[c] = c == 8'h0d ? w & `LIMIT_ENABLE_MASK :
                    c == 8'h0e ? w & `STATE_ENABLE_MASK : w;
        smbus_host_i.wr(`DEVICE_ADDR_DEFAULT, c, shadow[c], ok);
        check_bit(ok, 1'b1);
    endtask
    task get(input logic [7:0] c, input logic [15:0] want);
        smbus_host_i.rd(`DEVICE_ADDR_DEFAULT, c, rdw, ok);
        check_bit(ok, 1'b1);
        check_word(rdw, want);
    endtask
    // Alert, flag, response read, hold, clear; m selects input to restore
    task alert_seq(input logic [7:0] c, input int b, input int m,
                   input logic [15:0] v);
        repeat (12) @(posedge clk);
        @(negedge clk);
        check_bit(alert_oe, 1'b1);
        @(posedge clk);
        get(c + 8'h29, 16'h1 << b);
        smbus_host_i.ara(aid, ok);
        check_word({8'h0, aid}, {8'h0, `DEVICE_ADDR_DEFAULT, 1'b0});
        check_bit(alert_oe, 1'b0);
        meas[m] <= v;
        get(c + 8'h29, 16'h1 << b);
        put(c, 16'h0000);
        put(c + 8'h29, 16'h0000);
        get(c + 8'h29, 16'h0000);
    endtask
    task final_report;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (95000) @(posedge clk);
        mismatches++;
        final_report;
    end
    initial
    begin
        reset_n = 1'b0;
        {valid_ev, cnt_lo_ev, cnt_hi_ev, state_ev} = 19'h0;
        foreach (meas[i]) meas[i] = 16'h0;
        foreach (shadow[i]) shadow[i] = 16'h0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int c = 1; c <= 14; c++)
            get(8'(c), 16'h0000);
        for (int c = 1; c <= 14; c++)
        begin
            put(8'(c), 16'($random(seed)));
            get(8'(c), shadow[c]);
        end
        put(8'h0d, 16'hffff);
        get(8'h0d, 16'hbfff);
        put(8'h0e, 16'hffff);
        get(8'h0e, 16'h07c0);
        smbus_host_i.wr(`DEVICE_ADDR_DEFAULT, 8'h0f, 16'h5a5a, ok);
        get(8'h0f, 16'h0000);
        smbus_host_i.wr(7'h23, 8'h01, 16'h1234, ok);
        check_bit(ok, 1'b0);
        get(8'h01, shadow[1]);
        // Random enables may have raised flags; quiet everything first
        put(8'h0d, 16'h0000);
        put(8'h0e, 16'h0000);
        smbus_host_i.ara(aid, ok);
        put(8'h36, 16'h0000);
        put(8'h37, 16'h0000);
        {valid_ev, cnt_lo_ev, cnt_hi_ev, state_ev} <= {3'h7, 16'hffff};
        @(posedge clk);
        {valid_ev, cnt_lo_ev, cnt_hi_ev, state_ev} <= 19'h0;
        get(8'h36, 16'h0000);
        get(8'h37, 16'h0000);
        for (int c = 1; c <= 12; c++)
        begin
            lim = ($random(seed) & 1023) + 1;
            if (hi[c])
                lim = -lim;
            put(8'(c), 16'(lim));
            meas[mi[c]] <= 16'(lim);
            put(8'h0d, 16'h1 << (12 - c));
            get(8'h36, 16'h0000);
            meas[mi[c]] <= 16'(-lim);
            alert_seq(8'h0d, 12 - c, mi[c], 16'(lim));
        end
        for (int k = 0; k < 8; k++)
        begin
            eb = k < 3 ? (k == 0 ? 15 : 14 - k) : k + 3;
            ec = k < 3 ? 8'h0d : 8'h0e;
            put(ec, 16'h1 << eb);
            valid_ev <= k == 0;
            cnt_lo_ev <= k == 1;
            cnt_hi_ev <= k == 2;
            state_ev <= k < 3 ? 16'h0 : 16'h1 << eb;
            @(posedge clk);
            {valid_ev, cnt_lo_ev, cnt_hi_ev, state_ev} <= 19'h0;
            alert_seq(ec, eb, 8, 16'h0);
        end
        final_report;
    end
endmodule
